// >>> core/cap_trig_pkg.sv
// Package of constants and types for the capture trigger/sync control block
`default_nettype none
package cap_trig_pkg;
    // Register word address and field layout
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;  // capture_trigger_sync_control
    localparam logic [7:0]  ADDR_TIMER      = 8'h04;  // Channel timer, read only
    localparam int          BIT_CASCADE     = 8;
    localparam int          BIT_TRIG_CHOICE = 7;
    localparam int          BIT_TRIG_STAT   = 6;
    localparam int          SEL_W           = 5;
    localparam logic [15:0] CTRL_RESET      = 16'h000d;
    localparam logic [15:0] CTRL_WMASK      = 16'h01df;

    // Source codes at the edges of each group
    localparam logic [4:0] SEL_NONE     = 5'h00;
    localparam logic [4:0] SEL_OC_FIRST = 5'h01;
    localparam logic [4:0] SEL_OC_LAST  = 5'h09;
    localparam logic [4:0] SEL_IC5      = 5'h0a;
    localparam logic [4:0] SEL_TM_FIRST = 5'h0b;
    localparam logic [4:0] SEL_TM_LAST  = 5'h0f;
    localparam logic [4:0] SEL_IC7      = 5'h12;
    localparam logic [4:0] SEL_IC8      = 5'h13;
    localparam logic [4:0] SEL_IC1      = 5'h14;
    localparam logic [4:0] SEL_IC4      = 5'h17;
    localparam logic [4:0] SEL_CMP1     = 5'h18;
    localparam logic [4:0] SEL_CMP3     = 5'h1a;
    localparam logic [4:0] SEL_ADC      = 5'h1b;
    localparam logic [4:0] SEL_CTU      = 5'h1c;
    localparam logic [4:0] SEL_IC6      = 5'h1d;
    localparam logic [4:0] SEL_IC9      = 5'h1e;

    // Event sources offered to the selector, one pulse bit per module
    typedef struct packed {
        logic [8:0] compare;
        logic [8:0] capture;
        logic [4:0] timer;
        logic [2:0] comparator;
        logic       adc;
        logic       charge_time_unit;
    } event_src_s;

    // Decoded control fields
    typedef struct packed {
        logic             pair_cascade_enable;
        logic             trigger_sync_choice;
        logic [SEL_W-1:0] event_source_select;
    } ctrl_s;
endpackage : cap_trig_pkg
`default_nettype wire

// >>> core/capture_trigger_sync_control.sv
// Capture channel trigger/sync control register and timer gating
//
// Behaviour
// - Cascade bit set in both paired channels makes one 32-bit capture.
// - Hardware sets trigger status once the selected trigger event arrives.
// - Software writing one sets trigger status and starts the timer.
// - In trigger mode, trigger status zero holds the channel timer cleared.
// - Select code zero means free running, no sync or trigger.
// - Codes 1 to 9 pick compare channels 1 to 9.
// - Codes 0b to 0f pick timers 1 to 5.
// - Capture channels sit at codes 0a, 12, 13, 14-17, 1d, 1e.
// - Codes 18-1a comparators, 1b converter, 1c charge time unit.
//
// Decided for this implementation: the register offsets and the APB register port.
`default_nettype none
module capture_trigger_sync_control
    import cap_trig_pkg::*;
#(
    parameter int TIMER_W = 16
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire event_src_s         sources,
    input  wire logic               partner_cascade,
    input  wire logic               timer_tick,
    output logic                    cascade_active,
    output logic                    timer_run,
    output logic [TIMER_W-1:0]      timer_value,
    output logic                    sync_misuse
);
    // One channel's second control word. The selected source event either
    // restarts the timer (sync) or releases it once (trigger); code zero leaves
    // the channel free running. Only the status bit is written by hardware.

    // Register state and the next value of each
    logic [15:0]        ctrl_q;
    logic [15:0]        ctrl_d;
    logic               stat_q;
    logic               stat_d;
    logic [TIMER_W-1:0] tmr_q;
    logic [TIMER_W-1:0] tmr_d;
    logic [31:0]        rd_q;
    logic [31:0]        rd_d;
    // Outputs of the source selector
    logic               sel_evt;
    logic               trig_only;

    // Bus decode; pready is tied high, so every access ends in its first
    // access cycle and no wait state is ever inserted
    wire logic  access   = psel && penable;
    wire logic  setup    = psel && !penable;
    wire logic  hit_ctrl = (paddr == ADDR_CTRL);
    wire logic  hit_tmr  = (paddr == ADDR_TIMER);
    wire logic  wr_ctrl  = access && pwrite && hit_ctrl;
    wire logic  rd_setup = setup && !pwrite;
    assign pready = 1'b1;

    // Refused accesses: unmapped addresses, and writes to the read-only timer
    wire logic  bad_addr = !(hit_ctrl || hit_tmr);
    wire logic  bad_wr   = hit_tmr && pwrite;
    assign pslverr = access && (bad_addr || bad_wr);

    // Control fields as the rest of the block sees them
    wire ctrl_s ctrl     = '{ctrl_q[BIT_CASCADE], ctrl_q[BIT_TRIG_CHOICE], ctrl_q[SEL_W-1:0]};

    // Masked write data; unimplemented bits can never be stored
    wire logic [15:0] wr_word   = pwdata[15:0] & CTRL_WMASK;
    wire logic        wr_status = pwdata[BIT_TRIG_STAT];

    // Source selector; reserved codes give no event at all,
    // and trig_only marks the codes that may only trigger
    event_source_mux u_mux
    (
        .sel       (ctrl.event_source_select),
        .src       (sources),
        .evt       (sel_evt),
        .trig_only (trig_only)
    );

    wire logic free_run  = (ctrl.event_source_select == SEL_NONE);
    // choice bit splits trigger from sync
    wire logic trig_mode = !free_run && ctrl.trigger_sync_choice;
    wire logic sync_mode = !free_run && !ctrl.trigger_sync_choice;

    // Selected event qualified by the operating mode
    wire logic trig_hit  = trig_mode && sel_evt;
    wire logic sync_hit  = sync_mode && sel_evt;

    // misuse of trigger-only sources shows as a flag; nothing else changes
    assign sync_misuse = sync_mode && trig_only;

    // cascade only when both halves agree; the 32-bit data path lies outside
    assign cascade_active = ctrl.pair_cascade_enable && partner_cascade;

    // Control word; the status bit is kept apart since hardware also sets it
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
            ctrl_d = wr_word;
    end

    // Status: a hardware event in the same cycle as a software clear wins,
    // so a trigger that lands during a rewrite of the register is never lost
    always_comb
    begin
        stat_d = stat_q;
        if (wr_ctrl)
            stat_d = wr_status;
        if (trig_hit)
            stat_d = 1'b1;
    end

    // Outside trigger mode the timer is never held, so it runs freely;
    // in sync or free mode the status bit can still be read and written but
    // gates nothing
    assign timer_run = trig_mode ? stat_q : 1'b1;

    // Timer: held clear while untriggered, reset by every sync event;
    // a sync event beats a tick in the same cycle, so the count restarts at zero
    always_comb
    begin
        tmr_d = tmr_q;
        // held clear while status is zero in trigger mode
        if (!timer_run)
            tmr_d = '0;
        else if (sync_hit)
            tmr_d = '0;
        else if (timer_tick)
            tmr_d = tmr_q + TIMER_W'(1);
    end
    assign timer_value = tmr_q;

    // Read-back words; unimplemented bits read as zero
    wire logic [31:0] rd_ctrl_word  = {16'h0000, ctrl_q[15:7], stat_q, ctrl_q[5:0]};
    wire logic [31:0] rd_timer_word = {{(32-TIMER_W){1'b0}}, tmr_q};
    wire logic [31:0] rd_mux        = hit_ctrl ? rd_ctrl_word
                                    : hit_tmr  ? rd_timer_word
                                    : 32'h0000_0000;

    // Read data is taken in the setup cycle so it stands through the access phase;
    // the price is that a timer read shows the count of the setup cycle
    always_comb
    begin
        rd_d = rd_q;
        if (rd_setup)
            rd_d = rd_mux;
    end
    assign prdata = rd_q;

    // All state below resets asynchronously to constants only, matching the
    // power-on contents of the register; each register has a short process
    // of its own so its reset value and next value read at a glance

    // Control word register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // Trigger status register; reset clears it so a fresh channel
    // in trigger mode waits for its first event
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_q <= CTRL_RESET[BIT_TRIG_STAT];
        end
        else
        begin
            stat_q <= stat_d;
        end
    end

    // Channel timer register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tmr_q <= '0;
        end
        else
        begin
            tmr_q <= tmr_d;
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_q <= 32'h0000_0000;
        end
        else
        begin
            rd_q <= rd_d;
        end
    end
endmodule : capture_trigger_sync_control
`default_nettype wire

// >>> core/event_source_mux.sv
// Selector from source-select code to one event pulse
`default_nettype none
module event_source_mux
    import cap_trig_pkg::*;
(
    input  wire logic [SEL_W-1:0] sel,
    input  wire event_src_s       src,
    output logic                  evt,
    output logic                  trig_only
);
    wire logic [4:0] oc_idx = sel - SEL_OC_FIRST;
    wire logic [4:0] tm_idx = sel - SEL_TM_FIRST;
    wire logic [4:0] ic_idx = sel - SEL_IC1;
    wire logic [4:0] cm_idx = sel - SEL_CMP1;
    wire logic in_oc  = (sel >= SEL_OC_FIRST) && (sel <= SEL_OC_LAST);
    wire logic in_tm  = (sel >= SEL_TM_FIRST) && (sel <= SEL_TM_LAST);
    wire logic in_ic  = (sel >= SEL_IC1) && (sel <= SEL_IC4);
    wire logic in_cm  = (sel >= SEL_CMP1) && (sel <= SEL_CMP3);

    // Code zero and the reserved codes fall through to no event
    always_comb
    begin
        evt = 1'b0;
        if (in_oc)
            evt = src.compare[oc_idx[3:0]];
        else if (in_tm)
            evt = src.timer[tm_idx[2:0]];
        else if (in_ic)
            evt = src.capture[ic_idx[1:0]];
        else if (sel == SEL_IC5)
            evt = src.capture[4];
        else if (sel == SEL_IC6)
            evt = src.capture[5];
        else if (sel == SEL_IC7)
            evt = src.capture[6];
        else if (sel == SEL_IC8)
            evt = src.capture[7];
        else if (sel == SEL_IC9)
            evt = src.capture[8];
        else if (in_cm)
            evt = src.comparator[cm_idx[1:0]];
        else if (sel == SEL_ADC)
            evt = src.adc;
        else if (sel == SEL_CTU)
            evt = src.charge_time_unit;
    end

    assign trig_only = in_cm || (sel == SEL_ADC) || (sel == SEL_CTU);
endmodule : event_source_mux
`default_nettype wire

// >>> tb/cap_trig_monitor.sv
// Checker for the capture trigger/sync control block
`default_nettype none
module cap_trig_monitor
    import cap_trig_pkg::*;
#(parameter int TIMER_W = 16)
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire event_src_s         sources,
    input wire logic               partner_cascade,
    input wire logic               timer_tick,
    input wire logic               cascade_active,
    input wire logic               timer_run,
    input wire logic [TIMER_W-1:0] timer_value,
    input wire logic               sync_misuse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       casc_q;
    logic       trig_q;
    logic [4:0] sel_q;
    logic       wr;
    // Shadow of the written fields; the status bit is left to the design
    assign wr = psel && penable && pwrite && paddr == ADDR_CTRL;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {casc_q, trig_q, sel_q} <= {2'h0, CTRL_RESET[4:0]};
        else if (wr)
            {casc_q, trig_q, sel_q} <= {pwdata[8:7], pwdata[4:0]};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_casc; cascade_active == (casc_q && partner_cascade); endproperty
    a_casc: assert property (p_casc) else $error("cascade flag wrong");
    property p_trig; trig_q && sel_q == SEL_TM_FIRST && sources.timer[0] && !wr |-> ##[1:2] timer_run; endproperty
    a_trig: assert property (p_trig) else $error("trigger did not start timer");
    property p_sw; wr && pwdata[7:6] == 2'h3 |=> timer_run; endproperty
    a_sw: assert property (p_sw) else $error("software set did not start timer");
    property p_hold; !timer_run [*2] |-> timer_value == '0; endproperty
    a_hold: assert property (p_hold) else $error("held timer not clear");
    property p_free; sel_q == SEL_NONE |-> timer_run; endproperty
    a_free: assert property (p_free) else $error("free run stopped");
    property p_count; trig_q && timer_run && timer_tick && !psel |=> timer_value == TIMER_W'($past(timer_value) + 1); endproperty
    a_count: assert property (p_count) else $error("running timer did not count");
    property p_sync; !trig_q && sel_q == SEL_TM_FIRST && sources.timer[0] && !wr |-> ##[1:2] timer_value == '0; endproperty
    a_sync: assert property (p_sync) else $error("sync event did not clear timer");
    property p_mis; sync_misuse == (!trig_q && sel_q inside {[SEL_CMP1:SEL_CTU]}); endproperty
    a_mis: assert property (p_mis) else $error("misuse flag wrong");
    c_casc: cover property (cascade_active);
    c_trig: cover property (trig_q && $rose(timer_run));
    c_mis: cover property (sync_misuse);
endmodule : cap_trig_monitor
bind capture_trigger_sync_control cap_trig_monitor #(.TIMER_W(TIMER_W)) u_cap_trig_monitor
(
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .sources         (sources),
    .partner_cascade (partner_cascade),
    .timer_tick      (timer_tick),
    .cascade_active  (cascade_active),
    .timer_run       (timer_run),
    .timer_value     (timer_value),
    .sync_misuse     (sync_misuse)
);
`default_nettype wire

// >>> tb/event_partner.sv
// Far-side model: on-chip modules raising one-cycle event pulses
`default_nettype none
module event_partner
    import cap_trig_pkg::*;
(
    input  wire logic [27:0] fire,
    input  wire logic        pclk,
    output var event_src_s   sources
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each requested module pulses for as long as its fire bit is held; the pulse task holds it one clock
    always_ff @(posedge pclk)
        sources <= event_src_s'(fire);
endmodule : event_partner
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the capture trigger/sync control block
`default_nettype none
module testbench
    import cap_trig_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, partner_cascade = '0, timer_tick = 1'h1;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, er, cascade_active, timer_run, sync_misuse;
    logic [15:0] timer_value;
    logic [27:0] fire = '0;
    event_src_s  sources;
    int          fail_count = 0, n_checks = 0, cyc = 0;
    always #20 pclk = ~pclk;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge pclk)
        if (++cyc == 5000)
            end_sim(1);
    capture_trigger_sync_control #(.TIMER_W(16)) u_capture_trigger_sync_control
    (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .sources         (sources),
        .partner_cascade (partner_cascade),
        .timer_tick      (timer_tick),
        .cascade_active  (cascade_active),
        .timer_run       (timer_run),
        .timer_value     (timer_value),
        .sync_misuse     (sync_misuse)
    );
    event_partner u_event_partner
    (
        .fire    (fire),
        .pclk    (pclk),
        .sources (sources)
    );
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One APB transfer, request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    // Fire a set of source modules, let it land, then look at mid-cycle
    task automatic pulse(input logic [27:0] m);
        @(posedge pclk);
        fire <= m;
        @(posedge pclk);
        fire <= '0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : pulse
    // Position of each selectable module in the flattened source vector
    function automatic int src_bit(input logic [4:0] c);
        case (c) inside
            [5'h01:5'h09]: return c + 18;
            5'h0a: return 14;
            [5'h0b:5'h0f]: return c - 6;
            5'h12, 5'h13: return c - 2;
            [5'h14:5'h17]: return c - 10;
            [5'h18:5'h1a]: return c - 22;
            5'h1b: return 1;
            5'h1c: return 0;
            5'h1d: return 15;
            default: return 18;
        endcase
    endfunction : src_bit
    task automatic s_regs();
        apb(1'h0, ADDR_CTRL, '0);
        chk("ctrl reset", rd, {16'h0, CTRL_RESET});
        apb(1'h0, 8'h08, '0);
        chk("unmapped error", er, 1'h1);
    endtask : s_regs
    task automatic s_cascade_free();
        apb(1'h1, ADDR_CTRL, 32'h100);
        @(posedge pclk);
        partner_cascade <= 1'h1;
        @(negedge pclk);
        chk("cascade both", cascade_active, 1'h1);
        apb(1'h1, ADDR_CTRL, '0);
        pulse('1);
        chk("cascade one", cascade_active, 1'h0);
        chk("free run", timer_run, 1'h1);
    endtask : s_cascade_free
    task automatic s_trigger();
        for (int c = 1; c < 31; c++)
        begin
            if (c == 16 || c == 17)
                continue;
            apb(1'h1, ADDR_CTRL, 32'h80 | c);
            pulse(~(28'h1 << src_bit(c)));
            chk("held run", timer_run, 1'h0);
            chk("held timer", timer_value, 16'h0);
            apb(1'h1, ADDR_TIMER, '1);
            chk("timer write refused", er, 1'h1);
            apb(1'h0, ADDR_TIMER, '0);
            chk("held timer read", rd, 32'h0);
            pulse(28'h1 << src_bit(c));
            chk("triggered", timer_run, 1'h1);
        end
    endtask : s_trigger
    task automatic s_sw_sync();
        apb(1'h1, ADDR_CTRL, {24'h0, 3'h6, SEL_TM_FIRST});
        apb(1'h0, ADDR_CTRL, '0);
        chk("software set", rd[6], 1'h1);
        apb(1'h1, ADDR_CTRL, {27'h0, SEL_TM_FIRST});
        timer_tick <= 1'h0;
        pulse(28'h20);
        chk("sync clear", timer_value, 16'h0);
        timer_tick <= 1'h1;
        apb(1'h1, ADDR_CTRL, {27'h0, SEL_CMP1});
        @(negedge pclk);
        chk("sync misuse", sync_misuse, 1'h1);
    endtask : s_sw_sync
    task automatic end_sim(input int extra);
        fail_count += extra;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        s_regs();
        s_cascade_free();
        s_trigger();
        s_sw_sync();
        end_sim(0);
    end
endmodule : testbench
`default_nettype wire
